/* include/phy_bank_pkg.sv */
package phy_bank_pkg;
    // Register indices; byte address is four times the index
    localparam logic [9:0] IDX_PHY_CONFIG = 10'h310;
    localparam logic [9:0] IDX_LOOPBACK = 10'h313;
    localparam logic [9:0] IDX_FLAG_SELECT = 10'h314;
    localparam logic [9:0] IDX_FLAG_VALUES = 10'h315;
    localparam logic [9:0] IDX_TX_LOCK = 10'h320;
    localparam logic [9:0] IDX_RX_LOCK = 10'h321;
    localparam int unsigned ADDR_WIDTH = 12;
    localparam int unsigned IDX_LSB = 2;

    // Config field positions
    localparam int unsigned CFG_SYS_RST_BIT = 0;
    localparam int unsigned CFG_TXP_RST_BIT = 1;
    localparam int unsigned CFG_RXP_RST_BIT = 2;

    // Values after reset
    localparam logic [2:0] CONFIG_RESET = 3'h0;
    localparam logic [9:0] LOOPBACK_RESET = 10'h000;
    localparam logic [2:0] SELECT_RESET = 3'h0;
    localparam logic [9:0] LOCK_RESET = 10'h000;
    localparam logic [9:0] VALUES_RESET = 10'h000;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // FIFO flag select codes
    typedef enum logic [2:0] {
        SEL_TX_FULL = 3'h0,
        SEL_TX_EMPTY = 3'h1,
        SEL_TX_PFULL = 3'h2,
        SEL_TX_PEMPTY = 3'h3,
        SEL_RX_FULL = 3'h4,
        SEL_RX_EMPTY = 3'h5,
        SEL_RX_PFULL = 3'h6,
        SEL_RX_PEMPTY = 3'h7
    } flag_select_type;

    // Per-lane transceiver FIFO flags, lane n in bit n
    typedef struct packed {
        logic [9:0] rx_pempty;
        logic [9:0] rx_pfull;
        logic [9:0] rx_empty;
        logic [9:0] rx_full;
        logic [9:0] tx_pempty;
        logic [9:0] tx_pfull;
        logic [9:0] tx_empty;
        logic [9:0] tx_full;
    } fifo_flags_type;

    // Level-held PLL and PMA reset controls
    typedef struct packed {
        logic rx_pll_soft_reset;
        logic tx_pll_soft_reset;
        logic pma_sys_reset;
    } phy_control_type;
endpackage

/* rtl/phy_pll_loopback_fifo_status.sv */
// Design decision made here: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Overview of operation
// - Config bit 2 holds the receive PLL in soft reset.
// - Config bit 1 holds the transmit PLL in soft reset.
// - Config bit 0 holds the PMA system reset while set.
// - Each loopback bit puts its lane in serial loopback; resets zero, read-write.
// - CAUI-4 variants offer no serial loopback.
// - A 3-bit select code picks one FIFO flag, shown for every lane.
// - Codes 111,110,101,100 pick RX partial empty, partial full, empty, full.
// - Codes 011,010,001,000 pick TX partial empty, partial full, empty, full.
// - Bit n of the flag values register is lane n's selected flag.
// - Ten-lane variants carry ten valid flag bits.
// - CAUI-4 variants carry no valid flag content.
// - TX lock register shows per-lane TX PLL lock, resets to zero.
// - RX lock register shows per-lane RX CDR lock, resets to zero.
module phy_pll_loopback_fifo_status #(
    parameter int unsigned LANES = 10,
    parameter bit CAUI4 = 1'b0
) (
    input wire logic i_clock, // 100 MHz register clock
    input wire logic i_srst, // Synchronous reset, active high
    input wire logic i_awvalid, // Write address valid
    output logic o_awready, // Write address ready
    input wire logic [phy_bank_pkg::ADDR_WIDTH-1:0] i_awaddr, // Write byte address
    input wire logic [2:0] i_awprot, // Unused
    input wire logic i_wvalid, // Write data valid
    output logic o_wready, // Write data ready
    input wire logic [31:0] i_wdata, // Write data
    input wire logic [3:0] i_wstrb, // Byte enables
    output logic o_bvalid, // Write response valid
    input wire logic i_bready, // Write response ready
    output logic [1:0] o_bresp, // Write response
    input wire logic i_arvalid, // Read address valid
    output logic o_arready, // Read address ready
    input wire logic [phy_bank_pkg::ADDR_WIDTH-1:0] i_araddr, // Read byte address
    input wire logic [2:0] i_arprot, // Unused
    output logic o_rvalid, // Read data valid
    input wire logic i_rready, // Read data ready
    output logic [31:0] o_rdata, // Read data
    output logic [1:0] o_rresp, // Read response
    input wire phy_bank_pkg::fifo_flags_type i_fifo_flags, // Per-lane FIFO flags
    input wire logic [9:0] i_tx_pll_locked, // Per-lane TX PLL lock
    input wire logic [9:0] i_rx_cdr_locked, // Per-lane RX CDR lock
    output phy_bank_pkg::phy_control_type o_phy_control, // PLL and PMA resets
    output logic [9:0] o_serial_loopback // Per-lane serial loopback
);
    // Lanes above the variant width read as zero
    localparam logic [9:0] LANE_MASK = (LANES == 10) ? 10'h3FF : 10'h00F;
    localparam logic [9:0] LOOP_MASK = CAUI4 ? 10'h000 : LANE_MASK;

    // Refuse widths the lane logic cannot serve
    initial begin
        if (!(LANES == 10 || LANES == 4) || (CAUI4 && LANES != 4)) begin
            $error("LANES must be 10, or 4 for CAUI-4");
        end
    end

    logic aw_held, next_aw_held;
    logic w_held, next_w_held;
    logic [9:0] aw_idx, next_aw_idx;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic next_awready, next_wready, next_bvalid, next_arready, next_rvalid;
    logic [1:0] next_bresp, next_rresp;
    logic [31:0] next_rdata;
    phy_bank_pkg::phy_control_type next_phy_control;
    logic [9:0] loopback, next_loopback;
    phy_bank_pkg::flag_select_type flag_select, next_flag_select;
    logic [9:0] fifo_values, next_fifo_values;
    logic [9:0] tx_lock, rx_lock;

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);

    // Byte-lane merge; registers are at most ten bits wide
    function automatic logic [9:0] merge(input logic [9:0] old, input logic [31:0] d,
                                         input logic [3:0] s);
        logic [9:0] r;
        r = old;
        if (s[0]) begin
            r[7:0] = d[7:0];
        end
        if (s[1]) begin
            r[9:8] = d[9:8];
        end
        return r;
    endfunction

    // Flag multiplexer, selected flag for all lanes at once
    always_comb begin
        next_fifo_values = phy_bank_pkg::VALUES_RESET;
        case (flag_select)
            phy_bank_pkg::SEL_RX_PEMPTY: next_fifo_values = i_fifo_flags.rx_pempty;
            phy_bank_pkg::SEL_RX_PFULL: next_fifo_values = i_fifo_flags.rx_pfull;
            phy_bank_pkg::SEL_RX_EMPTY: next_fifo_values = i_fifo_flags.rx_empty;
            phy_bank_pkg::SEL_RX_FULL: next_fifo_values = i_fifo_flags.rx_full;
            phy_bank_pkg::SEL_TX_PEMPTY: next_fifo_values = i_fifo_flags.tx_pempty;
            phy_bank_pkg::SEL_TX_PFULL: next_fifo_values = i_fifo_flags.tx_pfull;
            phy_bank_pkg::SEL_TX_EMPTY: next_fifo_values = i_fifo_flags.tx_empty;
            default: next_fifo_values = i_fifo_flags.tx_full;
        endcase
        next_fifo_values = CAUI4 ? phy_bank_pkg::VALUES_RESET : (next_fifo_values & LANE_MASK);
    end

    // Status capture; one flop stage so lock bits track the lanes
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            fifo_values <= phy_bank_pkg::VALUES_RESET;
            tx_lock <= phy_bank_pkg::LOCK_RESET;
            rx_lock <= phy_bank_pkg::LOCK_RESET;
        end else begin
            fifo_values <= next_fifo_values;
            tx_lock <= i_tx_pll_locked & LANE_MASK;
            rx_lock <= i_rx_cdr_locked & LANE_MASK;
        end
    end

    // Bus slave next state; a write lands only while no response is pending
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_idx = aw_idx;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = o_bvalid;
        next_bresp = o_bresp;
        next_rvalid = o_rvalid;
        next_rdata = o_rdata;
        next_rresp = o_rresp;
        next_phy_control = o_phy_control;
        next_loopback = loopback;
        next_flag_select = flag_select;
        if (o_awready && i_awvalid) begin
            next_aw_held = 1'b1;
            next_aw_idx = i_awaddr[phy_bank_pkg::IDX_LSB +: 10];
        end
        if (o_wready && i_wvalid) begin
            next_w_held = 1'b1;
            next_w_data = i_wdata;
            next_w_strb = i_wstrb;
        end
        if (o_bvalid && i_bready) begin
            next_bvalid = 1'b0;
        end else if (!o_bvalid && next_aw_held && next_w_held) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = phy_bank_pkg::RESP_OKAY;
            if (next_aw_idx == phy_bank_pkg::IDX_PHY_CONFIG) begin
                if (next_w_strb[0]) begin
                    next_phy_control.rx_pll_soft_reset =
                        next_w_data[phy_bank_pkg::CFG_RXP_RST_BIT];
                    next_phy_control.tx_pll_soft_reset =
                        next_w_data[phy_bank_pkg::CFG_TXP_RST_BIT];
                    next_phy_control.pma_sys_reset =
                        next_w_data[phy_bank_pkg::CFG_SYS_RST_BIT];
                end
            end else if (next_aw_idx == phy_bank_pkg::IDX_LOOPBACK) begin
                next_loopback = merge(loopback, next_w_data, next_w_strb) & LOOP_MASK;
            end else if (next_aw_idx == phy_bank_pkg::IDX_FLAG_SELECT) begin
                if (next_w_strb[0]) begin
                    next_flag_select = phy_bank_pkg::flag_select_type'(next_w_data[2:0]);
                end
            end else if (next_aw_idx == phy_bank_pkg::IDX_FLAG_VALUES ||
                         next_aw_idx == phy_bank_pkg::IDX_TX_LOCK ||
                         next_aw_idx == phy_bank_pkg::IDX_RX_LOCK) begin
                next_bresp = phy_bank_pkg::RESP_OKAY; // Read-only, write ignored
            end else begin
                next_bresp = phy_bank_pkg::RESP_SLVERR;
            end
        end
        if (o_rvalid && i_rready) begin
            next_rvalid = 1'b0;
        end else if (o_arready && i_arvalid) begin
            next_rvalid = 1'b1;
            next_rresp = phy_bank_pkg::RESP_OKAY;
            next_rdata = 32'h0000_0000;
            if (i_araddr[phy_bank_pkg::IDX_LSB +: 10] == phy_bank_pkg::IDX_PHY_CONFIG) begin
                next_rdata[2:0] = o_phy_control;
            end else if (i_araddr[phy_bank_pkg::IDX_LSB +: 10] == phy_bank_pkg::IDX_LOOPBACK) begin
                next_rdata[9:0] = loopback;
            end else if (i_araddr[phy_bank_pkg::IDX_LSB +: 10] == phy_bank_pkg::IDX_FLAG_SELECT) begin
                next_rdata[2:0] = flag_select;
            end else if (i_araddr[phy_bank_pkg::IDX_LSB +: 10] == phy_bank_pkg::IDX_FLAG_VALUES) begin
                next_rdata[9:0] = fifo_values;
            end else if (i_araddr[phy_bank_pkg::IDX_LSB +: 10] == phy_bank_pkg::IDX_TX_LOCK) begin
                next_rdata[9:0] = tx_lock;
            end else if (i_araddr[phy_bank_pkg::IDX_LSB +: 10] == phy_bank_pkg::IDX_RX_LOCK) begin
                next_rdata[9:0] = rx_lock;
            end else begin
                next_rresp = phy_bank_pkg::RESP_SLVERR;
            end
        end
        // Readies drop while a channel is held, so a second write waits for the first
        next_awready = !next_aw_held && !next_bvalid;
        next_wready = !next_w_held && !next_bvalid;
        next_arready = !next_rvalid;
    end

    // Bus slave and control registers
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_idx <= 10'h000;
            w_data <= 32'h0000_0000;
            w_strb <= 4'h0;
            o_awready <= 1'b0;
            o_wready <= 1'b0;
            o_bvalid <= 1'b0;
            o_bresp <= phy_bank_pkg::RESP_OKAY;
            o_arready <= 1'b0;
            o_rvalid <= 1'b0;
            o_rdata <= 32'h0000_0000;
            o_rresp <= phy_bank_pkg::RESP_OKAY;
            o_phy_control <= phy_bank_pkg::CONFIG_RESET;
            loopback <= phy_bank_pkg::LOOPBACK_RESET;
            flag_select <= phy_bank_pkg::flag_select_type'(phy_bank_pkg::SELECT_RESET);
            o_serial_loopback <= phy_bank_pkg::LOOPBACK_RESET;
        end else begin
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_idx <= next_aw_idx;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            o_awready <= next_awready;
            o_wready <= next_wready;
            o_bvalid <= next_bvalid;
            o_bresp <= next_bresp;
            o_arready <= next_arready;
            o_rvalid <= next_rvalid;
            o_rdata <= next_rdata;
            o_rresp <= next_rresp;
            o_phy_control <= next_phy_control;
            loopback <= next_loopback;
            flag_select <= next_flag_select;
            o_serial_loopback <= next_loopback;
        end
    end

    // Checks on the control writes
    a_rx_pll_reset: assert property (
        $rose(o_bvalid) && aw_idx == phy_bank_pkg::IDX_PHY_CONFIG && w_strb[0]
        |-> o_phy_control.rx_pll_soft_reset == w_data[2])
        else $error("RX PLL reset bit not written");
    a_tx_pll_reset: assert property (
        $rose(o_bvalid) && aw_idx == phy_bank_pkg::IDX_PHY_CONFIG && w_strb[0]
        |-> o_phy_control.tx_pll_soft_reset == w_data[1])
        else $error("TX PLL reset bit not written");
    a_pma_sys_reset: assert property (
        $rose(o_bvalid) && aw_idx == phy_bank_pkg::IDX_PHY_CONFIG && w_strb[0]
        |-> o_phy_control.pma_sys_reset == w_data[0])
        else $error("PMA reset bit not written");
    a_control_held: assert property (
        !($rose(o_bvalid) && aw_idx == phy_bank_pkg::IDX_PHY_CONFIG)
        |-> $stable(o_phy_control))
        else $error("Reset control changed without a write");
    a_loopback_write: assert property (
        $rose(o_bvalid) && aw_idx == phy_bank_pkg::IDX_LOOPBACK && w_strb[1:0] == 2'h3
        |=> o_serial_loopback == (w_data[9:0] & LOOP_MASK))
        else $error("Loopback lanes not applied");
    a_select_write: assert property (
        $rose(o_bvalid) && aw_idx == phy_bank_pkg::IDX_FLAG_SELECT && w_strb[0]
        |-> flag_select == w_data[2:0])
        else $error("Flag select code not written");
    a_loopback_caui4: assert property (CAUI4 |-> o_serial_loopback == 10'h000)
        else $error("Loopback active in CAUI-4 variant");
    // No attempt on the release edge: the capture flops still load reset values there
    a_rx_flag_pick: assert property (
        !i_srst && flag_select == phy_bank_pkg::SEL_RX_PEMPTY && $stable(flag_select)
        |=> fifo_values == ($past(i_fifo_flags.rx_pempty) & (CAUI4 ? 10'h000 : LANE_MASK)))
        else $error("RX partial empty not selected");
    a_tx_flag_pick: assert property (
        !i_srst && flag_select == phy_bank_pkg::SEL_TX_FULL && $stable(flag_select)
        |=> fifo_values == ($past(i_fifo_flags.tx_full) & (CAUI4 ? 10'h000 : LANE_MASK)))
        else $error("TX full not selected");
    a_values_read: assert property (
        o_arready && i_arvalid && i_araddr[11:2] == phy_bank_pkg::IDX_FLAG_VALUES
        |=> o_rvalid && o_rdata == {22'h000000, $past(fifo_values)})
        else $error("Flag values read mismatch");
    a_values_caui4: assert property (CAUI4 |-> ##1 fifo_values == 10'h000)
        else $error("Flag values present in CAUI-4 variant");
    a_tx_lock_track: assert property (
        !i_srst
        |=> tx_lock == ($past(i_tx_pll_locked) & LANE_MASK))
        else $error("TX lock bits do not track lanes");
    a_rx_lock_track: assert property (
        !i_srst
        |=> rx_lock == ($past(i_rx_cdr_locked) & LANE_MASK))
        else $error("RX lock bits do not track lanes");

    // Main scenarios the bench should reach
    c_config_write: cover property ($rose(o_bvalid) && aw_idx == phy_bank_pkg::IDX_PHY_CONFIG);
    c_values_read: cover property (o_rvalid && i_rready && o_rdata[9:0] != 10'h000);
    c_bad_address: cover property (o_bvalid && o_bresp == phy_bank_pkg::RESP_SLVERR);
    c_loopback_on: cover property (o_serial_loopback != 10'h000);
    c_rx_flag_seen: cover property (flag_select == phy_bank_pkg::SEL_RX_PEMPTY && fifo_values != 10'h000);
endmodule

/* sim/phy_pll_loopback_fifo_status_test.sv */
`timescale 1ns/10ps
module phy_pll_loopback_fifo_status_test;
    logic i_clock, i_srst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready;
    logic [phy_bank_pkg::ADDR_WIDTH-1:0] i_awaddr, i_araddr;
    logic [31:0] i_wdata;
    logic [3:0] i_wstrb;
    logic [9:0] i_tx_pll_locked, i_rx_cdr_locked;
    phy_bank_pkg::fifo_flags_type i_fifo_flags;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid;
    logic [1:0] o_bresp, o_rresp;
    logic [31:0] o_rdata;
    phy_bank_pkg::phy_control_type o_phy_control;
    logic [9:0] o_serial_loopback;
    logic [31:0] rdata_caui4;
    logic [9:0] loop_caui4;
    logic [31:0] seed = 32'h2D227C32;
    int miscompares = 0;
    int compares = 0;
    int k;
    logic [31:0] v;
    logic [3:0] s;
    logic [1:0] r;
    logic [9:0] exp10;
    logic [95:0] wide;
    logic [9:0] idx_table [6] = '{phy_bank_pkg::IDX_PHY_CONFIG, phy_bank_pkg::IDX_LOOPBACK,
        phy_bank_pkg::IDX_FLAG_SELECT, phy_bank_pkg::IDX_FLAG_VALUES,
        phy_bank_pkg::IDX_TX_LOCK, phy_bank_pkg::IDX_RX_LOCK};

    // Protection bits are not decoded, so they stay tied
    phy_pll_loopback_fifo_status uut (
        .i_clock(i_clock), .i_srst(i_srst), .i_awvalid(i_awvalid), .o_awready(o_awready),
        .i_awaddr(i_awaddr), .i_awprot(3'h0), .i_wvalid(i_wvalid), .o_wready(o_wready),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(o_bvalid), .i_bready(i_bready),
        .o_bresp(o_bresp), .i_arvalid(i_arvalid), .o_arready(o_arready), .i_araddr(i_araddr),
        .i_arprot(3'h0), .o_rvalid(o_rvalid), .i_rready(i_rready), .o_rdata(o_rdata),
        .o_rresp(o_rresp), .i_fifo_flags(i_fifo_flags), .i_tx_pll_locked(i_tx_pll_locked),
        .i_rx_cdr_locked(i_rx_cdr_locked), .o_phy_control(o_phy_control),
        .o_serial_loopback(o_serial_loopback)
    );

    // Four-lane CAUI-4 variant on the same inputs; its bus timing matches uut exactly
    phy_pll_loopback_fifo_status #(.LANES(4), .CAUI4(1'b1)) uut_caui4 (
        .i_clock(i_clock), .i_srst(i_srst), .i_awvalid(i_awvalid), .o_awready(),
        .i_awaddr(i_awaddr), .i_awprot(3'h0), .i_wvalid(i_wvalid), .o_wready(),
        .i_wdata(i_wdata), .i_wstrb(i_wstrb), .o_bvalid(), .i_bready(i_bready),
        .o_bresp(), .i_arvalid(i_arvalid), .o_arready(), .i_araddr(i_araddr),
        .i_arprot(3'h0), .o_rvalid(), .i_rready(i_rready), .o_rdata(rdata_caui4),
        .o_rresp(), .i_fifo_flags(i_fifo_flags), .i_tx_pll_locked(i_tx_pll_locked),
        .i_rx_cdr_locked(i_rx_cdr_locked), .o_phy_control(),
        .o_serial_loopback(loop_caui4)
    );

    // Free-running 100 MHz clock
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end

    // Repeatable xorshift source
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected flag vector for a select code
    function automatic logic [9:0] flag_pick(input phy_bank_pkg::fifo_flags_type f,
                                             input logic [2:0] c);
        case (c)
            3'h0: return f.tx_full;
            3'h1: return f.tx_empty;
            3'h2: return f.tx_pfull;
            3'h3: return f.tx_pempty;
            3'h4: return f.rx_full;
            3'h5: return f.rx_empty;
            3'h6: return f.rx_pfull;
            default: return f.rx_pempty;
        endcase
    endfunction

    task automatic compare(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Master flops are read right after the edge, so both sides show pre-edge values
    task automatic axi_write(input logic [9:0] idx, input logic [31:0] d, input logic [3:0] st,
                             output logic [1:0] resp);
        bit done;
        done = 1'b0;
        resp = 2'h0;
        @(posedge i_clock);
        i_awvalid <= 1'b1;
        i_awaddr <= {idx, 2'h0};
        i_wvalid <= 1'b1;
        i_wdata <= d;
        i_wstrb <= st;
        i_bready <= 1'b1;
        // Only the watchdog ends a wait that never gets its answer
        while (!done) begin
            @(posedge i_clock);
            if (i_awvalid && o_awready) i_awvalid <= 1'b0;
            if (i_wvalid && o_wready) i_wvalid <= 1'b0;
            if (i_bready && o_bvalid) begin
                resp = o_bresp;
                i_bready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
        bit done;
        done = 1'b0;
        @(posedge i_clock);
        i_arvalid <= 1'b1;
        i_araddr <= {idx, 2'h0};
        i_rready <= 1'b1;
        while (!done) begin
            @(posedge i_clock);
            if (i_arvalid && o_arready) i_arvalid <= 1'b0;
            if (i_rready && o_rvalid) begin
                compare("read data", exp, o_rdata);
                compare("read resp", {30'h0, er}, {30'h0, o_rresp});
                i_rready <= 1'b0;
                done = 1'b1;
            end
        end
    endtask

    task automatic complete_run();
        if (miscompares == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {i_srst, i_awvalid, i_wvalid, i_bready, i_arvalid, i_rready} = 6'h20;
        {i_awaddr, i_araddr, i_wdata, i_wstrb} = '0;
        {i_tx_pll_locked, i_rx_cdr_locked, i_fifo_flags} = '0;
        exp10 = 10'h000;
        repeat (4) @(posedge i_clock);
        i_srst <= 1'b0;
        repeat (3) @(posedge i_clock);
        foreach (idx_table[j]) rd_chk(idx_table[j], 32'h0, phy_bank_pkg::RESP_OKAY);
        // Every combination of the three reset controls
        for (k = 0; k < 8; k++) begin
            v = rnd();
            v[2:0] = k[2:0];
            axi_write(phy_bank_pkg::IDX_PHY_CONFIG, v, 4'hF, r);
            compare("control", 32'(k), {29'h0, o_phy_control});
            rd_chk(phy_bank_pkg::IDX_PHY_CONFIG, 32'(k), phy_bank_pkg::RESP_OKAY);
        end
        // Write without the low byte lane leaves the controls held
        axi_write(phy_bank_pkg::IDX_PHY_CONFIG, 32'h0, 4'hE, r);
        repeat (20) @(posedge i_clock);
        compare("control", 32'h7, {29'h0, o_phy_control});
        // Loopback lanes, last write with only the low byte lane
        for (k = 0; k < 6; k++) begin
            v = rnd();
            s = (k == 5) ? 4'h1 : 4'hF;
            exp10 = s[1] ? v[9:0] : {exp10[9:8], v[7:0]};
            axi_write(phy_bank_pkg::IDX_LOOPBACK, v, s, r);
            compare("loopback out", {22'h0, exp10}, {22'h0, o_serial_loopback});
            compare("caui4 loopback", 32'h0, {22'h0, loop_caui4});
            rd_chk(phy_bank_pkg::IDX_LOOPBACK, {22'h0, exp10}, phy_bank_pkg::RESP_OKAY);
        end
        // Every flag code, flags changed after the select write
        for (k = 0; k < 8; k++) begin
            axi_write(phy_bank_pkg::IDX_FLAG_SELECT, 32'(k), 4'hF, r);
            rd_chk(phy_bank_pkg::IDX_FLAG_SELECT, 32'(k), phy_bank_pkg::RESP_OKAY);
            wide = {rnd(), rnd(), rnd()};
            i_fifo_flags <= wide[79:0];
            repeat (3) @(posedge i_clock);
            v = {22'h0, flag_pick(wide[79:0], k[2:0])};
            rd_chk(phy_bank_pkg::IDX_FLAG_VALUES, v, phy_bank_pkg::RESP_OKAY);
            compare("caui4 flag values", 32'h0, rdata_caui4);
        end
        // Lock status, all-locked corner first; the four-lane variant keeps lanes 3:0
        for (k = 0; k < 4; k++) begin
            v = (k == 0) ? 32'hFFFFFFFF : rnd();
            i_tx_pll_locked <= v[9:0];
            i_rx_cdr_locked <= v[25:16];
            repeat (2) @(posedge i_clock);
            rd_chk(phy_bank_pkg::IDX_TX_LOCK, {22'h0, v[9:0]}, phy_bank_pkg::RESP_OKAY);
            compare("caui4 tx lock", {28'h0, v[3:0]}, rdata_caui4);
            rd_chk(phy_bank_pkg::IDX_RX_LOCK, {22'h0, v[25:16]}, phy_bank_pkg::RESP_OKAY);
            compare("caui4 rx lock", {28'h0, v[19:16]}, rdata_caui4);
        end
        // Read-only write is accepted and ignored; unmapped place refused
        axi_write(phy_bank_pkg::IDX_TX_LOCK, ~v, 4'hF, r);
        compare("write resp", {30'h0, phy_bank_pkg::RESP_OKAY}, {30'h0, r});
        rd_chk(phy_bank_pkg::IDX_TX_LOCK, {22'h0, v[9:0]}, phy_bank_pkg::RESP_OKAY);
        axi_write(10'h300, 32'h1, 4'hF, r);
        compare("write resp", {30'h0, phy_bank_pkg::RESP_SLVERR}, {30'h0, r});
        rd_chk(10'h300, 32'h0, phy_bank_pkg::RESP_SLVERR);
        // Reset in mid-run clears the held controls
        i_srst <= 1'b1;
        repeat (4) @(posedge i_clock);
        i_srst <= 1'b0;
        repeat (3) @(posedge i_clock);
        compare("control", 32'h0, {29'h0, o_phy_control});
        compare("loopback out", 32'h0, {22'h0, o_serial_loopback});
        complete_run();
    end

    // Watchdog well beyond the expected run length
    initial begin
        repeat (20000) @(posedge i_clock);
        miscompares++;
        complete_run();
    end
endmodule
